// file: rtl/pcg_top.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] a unit gets its clock while its gating bit is 1 and none while it is 0.
// [RULE2] an access to a unit whose clock is off is answered with a bus fault.
// [RULE3] every gating bit is 0 after reset so all units start unclocked.
// [RULE4] the run-mode second gating register sits at offset 0x108 from base 0x400F_E000.
// [RULE5] three gating sets exist, for run, sleep and deep-sleep.
// [RULE6] sleep and deep-sleep sets apply only while the auto gating bit is set.
// [RULE7] bit 16 of the second gating register gates the usb controller.
// [RULE8] bit 13 of the second gating register gates the micro-dma engine.
// [RULE9] bits 4 to 0 of the second gating register gate ports e, d, c, b and a.
// [RULE10] bits 17 and 16 of the first gating register gate timers one and zero.
// [RULE11] bit 12 of the first gating register gates the two-wire serial module.
// [RULE12] bit 4 of the first gating register gates the synchronous serial module.
// [RULE13] bit 0 of the first gating register gates the asynchronous serial port.
// [RULE14] software preserves reserved bits and does not rely on their value.
// [RULE15] software enables each unit it uses before touching it.
// [RULE16] the sleep copy of the second gating register sits at offset 0x118.
// [RULE17] clock enables switch the unit clocks without runt pulses.
module pcg_top #(
    parameter logic [31:0] BASE = pcg_pkg::BASE_ADDR
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power mode from the core
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    // peripheral access check from the system bus decoder
    input wire logic periph_access,
    input wire logic [pcg_pkg::NUM_UNITS-1:0] periph_sel,
    output logic periph_fault,
    // gated unit clocks and their enables
    output logic [pcg_pkg::NUM_UNITS-1:0] unit_clk,
    output logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_en,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------

    // merge bus data into a register under byte strobes and a writable mask
    function automatic logic [31:0] apply_wr(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~lanes) | (data & lanes)) & mask;
    endfunction : apply_wr

    // collect the unit enables from one pair of gating registers
    // unit order: async serial, sync serial, two-wire, timer_zero_gate, timer_one_gate,
    // port a..e, micro-dma, usb
    function automatic logic [pcg_pkg::NUM_UNITS-1:0] unit_vec(
        input logic [31:0] one,
        input logic [31:0] two
    );
        return {two[pcg_pkg::BIT_USB_CTRL], // RULE7
                two[pcg_pkg::BIT_MICRO_DMA], // RULE8
                two[pcg_pkg::BIT_PORT_E:pcg_pkg::BIT_PORT_A], // RULE9
                one[pcg_pkg::BIT_TIMER_ONE], // RULE10
                one[pcg_pkg::BIT_TIMER_ZERO], // RULE10
                one[pcg_pkg::BIT_TWO_WIRE], // RULE11
                one[pcg_pkg::BIT_SYNC_SERIAL], // RULE12
                one[pcg_pkg::BIT_ASYNC_SERIAL]}; // RULE13
    endfunction : unit_vec

    // ------------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------------

    logic wr_req;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_req;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    pcg_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------

    logic wr_in_win;
    logic rd_in_win;
    logic [11:0] wr_off;
    logic [11:0] rd_off;
    logic wr_run1;
    logic wr_run2;
    logic wr_slp1;
    logic wr_slp2;
    logic wr_dsl1;
    logic wr_dsl2;
    logic wr_rcc;
    logic wr_sts;
    logic wr_msk;
    logic wr_ro;

    // window match on the upper bits, offset below
    assign wr_in_win = (wr_addr[31:12] == BASE[31:12]);
    assign rd_in_win = (rd_addr[31:12] == BASE[31:12]);
    assign wr_off = wr_addr[11:0];
    assign rd_off = rd_addr[11:0];

    // write selects, each qualified by the request except the read-only match wr_ro
    assign wr_run1 = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_RUN_GATE_ONE);
    assign wr_run2 = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_RUN_GATE_TWO); // RULE4
    assign wr_slp1 = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_SLEEP_GATE_ONE);
    assign wr_slp2 = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_SLEEP_GATE_TWO); // RULE16
    assign wr_dsl1 = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_DEEP_GATE_ONE);
    assign wr_dsl2 = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_DEEP_GATE_TWO);
    assign wr_rcc = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_RUN_CLOCK_CONFIG);
    assign wr_sts = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_INT_STATUS);
    assign wr_msk = wr_req && wr_in_win && (wr_off == pcg_pkg::OFF_INT_MASK);
    assign wr_ro = wr_in_win && ((wr_off == pcg_pkg::OFF_FAULT_UNITS) ||
                                 (wr_off == pcg_pkg::OFF_ACTIVE_GATES));

    // unmapped writes get slverr, read-only ones are dropped quietly
    assign wr_err = !(wr_run1 || wr_run2 || wr_slp1 || wr_slp2 || wr_dsl1 || wr_dsl2 ||
                      wr_rcc || wr_sts || wr_msk || wr_ro);

    // ------------------------------------------------------------------------
    // gating registers, three sets
    // ------------------------------------------------------------------------

    logic [31:0] run1_q;
    logic [31:0] run2_q;
    logic [31:0] slp1_q;
    logic [31:0] slp2_q;
    logic [31:0] dsl1_q;
    logic [31:0] dsl2_q;
    logic [31:0] rcc_q;

    // run set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run1_q <= pcg_pkg::RST_GATE; // RULE3
            run2_q <= pcg_pkg::RST_GATE; // RULE3
        end else begin
            if (wr_run1) run1_q <= apply_wr(run1_q, wr_data, wr_strb, pcg_pkg::MASK_GATE_ONE);
            if (wr_run2) run2_q <= apply_wr(run2_q, wr_data, wr_strb, pcg_pkg::MASK_GATE_TWO);
        end
    end

    // sleep set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slp1_q <= pcg_pkg::RST_GATE; // RULE3
            slp2_q <= pcg_pkg::RST_GATE; // RULE3
        end else begin
            if (wr_slp1) slp1_q <= apply_wr(slp1_q, wr_data, wr_strb, pcg_pkg::MASK_GATE_ONE);
            if (wr_slp2) slp2_q <= apply_wr(slp2_q, wr_data, wr_strb, pcg_pkg::MASK_GATE_TWO);
        end
    end

    // deep-sleep set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dsl1_q <= pcg_pkg::RST_GATE; // RULE3
            dsl2_q <= pcg_pkg::RST_GATE; // RULE3
        end else begin
            if (wr_dsl1) dsl1_q <= apply_wr(dsl1_q, wr_data, wr_strb, pcg_pkg::MASK_GATE_ONE);
            if (wr_dsl2) dsl2_q <= apply_wr(dsl2_q, wr_data, wr_strb, pcg_pkg::MASK_GATE_TWO);
        end
    end

    // run clock configuration, auto gating bit only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rcc_q <= pcg_pkg::RST_ZERO;
        end else if (wr_rcc) begin
            rcc_q <= apply_wr(rcc_q, wr_data, wr_strb, pcg_pkg::MASK_CLOCK_CONFIG);
        end
    end

    // ------------------------------------------------------------------------
    // active set selection
    // ------------------------------------------------------------------------

    logic auto_gating_select;
    pcg_pkg::pcg_mode_e mode_d;
    pcg_pkg::pcg_mode_e mode_q;
    logic [pcg_pkg::NUM_UNITS-1:0] run_set;
    logic [pcg_pkg::NUM_UNITS-1:0] sleep_set;
    logic [pcg_pkg::NUM_UNITS-1:0] deep_set;
    logic [pcg_pkg::NUM_UNITS-1:0] gate_d;
    logic [pcg_pkg::NUM_UNITS-1:0] gate_q;

    // enable vectors of the three sets
    assign run_set = unit_vec(run1_q, run2_q); // RULE5
    assign sleep_set = unit_vec(slp1_q, slp2_q); // RULE5
    assign deep_set = unit_vec(dsl1_q, dsl2_q); // RULE5

    // low-power sets only count with auto gating on, deep wins over sleep
    assign auto_gating_select = rcc_q[pcg_pkg::BIT_AUTO_GATING];
    assign mode_d = !auto_gating_select ? pcg_pkg::MODE_RUN : // RULE6
                    deep_sleep_mode ? pcg_pkg::MODE_DEEP :
                    sleep_mode ? pcg_pkg::MODE_SLEEP : pcg_pkg::MODE_RUN;

    // set picked by the current mode, drives the clocks one cycle later through gate_q
    always_comb begin
        case (mode_d)
            pcg_pkg::MODE_RUN: gate_d = run_set;
            pcg_pkg::MODE_SLEEP: gate_d = sleep_set;
            pcg_pkg::MODE_DEEP: gate_d = deep_set;
            default: gate_d = run_set;
        endcase
    end

    // registered enables, all off after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_q <= '0; // RULE3
            mode_q <= pcg_pkg::MODE_RUN;
        end else begin
            gate_q <= gate_d; // RULE1
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------------
    // unit clocks
    // ------------------------------------------------------------------------

    // latch-based gates keep every clock edge whole
    pcg_clk_gate #(
        .N(pcg_pkg::NUM_UNITS)
    ) u_gate (
        .clk_in(aclk),
        .en(gate_q), // RULE17
        .clk_out(unit_clk) // RULE1
    );

    assign unit_clk_en = gate_q;

    // ------------------------------------------------------------------------
    // access check and events
    // ------------------------------------------------------------------------

    logic [pcg_pkg::NUM_UNITS-1:0] fault_hit;
    logic [pcg_pkg::NUM_UNITS-1:0] fault_units_q;
    logic evt_fault;
    logic evt_mode;
    logic [31:0] int_sts_q;
    logic [31:0] int_msk_q;
    logic [31:0] evt_vec;
    logic [31:0] clr_vec;

    // an access to any unit with its clock off faults
    assign fault_hit = periph_sel & ~gate_q;
    assign periph_fault = periph_access && (|fault_hit); // RULE2
    assign evt_fault = periph_fault;
    assign evt_mode = (mode_d != mode_q);

    // event and clear vectors, set wins over a clear in the same cycle
    assign evt_vec = {30'h0000_0000, evt_mode, evt_fault};
    assign clr_vec = wr_sts ? apply_wr(32'h0000_0000, wr_data, wr_strb, pcg_pkg::MASK_INT)
                            : 32'h0000_0000;

    // sticky status, write one to clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_sts_q <= pcg_pkg::RST_ZERO;
        end else begin
            int_sts_q <= ((int_sts_q & ~clr_vec) | evt_vec) & pcg_pkg::MASK_INT;
        end
    end

    // interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_msk_q <= pcg_pkg::RST_ZERO;
        end else if (wr_msk) begin
            int_msk_q <= apply_wr(int_msk_q, wr_data, wr_strb, pcg_pkg::MASK_INT);
        end
    end

    // units hit by the latest faulting access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_units_q <= '0;
        end else if (periph_fault) begin
            fault_units_q <= fault_hit; // RULE2
        end
    end

    assign irq = |(int_sts_q & int_msk_q);

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------

    logic [31:0] fault_word;
    logic [31:0] active_word;

    assign fault_word = {{(32 - pcg_pkg::NUM_UNITS){1'b0}}, fault_units_q};
    assign active_word = {{(32 - pcg_pkg::NUM_UNITS){1'b0}}, gate_q};

    // reserved bits are never stored, so they read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (!rd_in_win) begin
            rd_err = 1'b1;
        end else begin
            case (rd_off)
                pcg_pkg::OFF_RUN_GATE_ONE: rd_data = run1_q;
                pcg_pkg::OFF_RUN_GATE_TWO: rd_data = run2_q; // RULE4
                pcg_pkg::OFF_SLEEP_GATE_ONE: rd_data = slp1_q;
                pcg_pkg::OFF_SLEEP_GATE_TWO: rd_data = slp2_q; // RULE16
                pcg_pkg::OFF_DEEP_GATE_ONE: rd_data = dsl1_q;
                pcg_pkg::OFF_DEEP_GATE_TWO: rd_data = dsl2_q;
                pcg_pkg::OFF_RUN_CLOCK_CONFIG: rd_data = rcc_q;
                pcg_pkg::OFF_INT_STATUS: rd_data = int_sts_q;
                pcg_pkg::OFF_INT_MASK: rd_data = int_msk_q;
                pcg_pkg::OFF_FAULT_UNITS: rd_data = fault_word;
                pcg_pkg::OFF_ACTIVE_GATES: rd_data = active_word;
                default: rd_err = 1'b1;
            endcase
        end
    end

endmodule : pcg_top
`default_nettype wire

// file: common/pcg_pkg.sv
// ----------------------------------------------------------------------------
// peripheral clock gating constants
// ----------------------------------------------------------------------------
package pcg_pkg;

    // system control base and window
    localparam logic [31:0] BASE_ADDR = 32'h400F_E000;
    localparam int OFFS_W = 12;

    // register offsets inside the window
    localparam logic [11:0] OFF_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [11:0] OFF_RUN_GATE_ONE = 12'h100;
    localparam logic [11:0] OFF_RUN_GATE_TWO = 12'h108;
    localparam logic [11:0] OFF_SLEEP_GATE_ONE = 12'h110;
    localparam logic [11:0] OFF_SLEEP_GATE_TWO = 12'h118;
    localparam logic [11:0] OFF_DEEP_GATE_ONE = 12'h120;
    localparam logic [11:0] OFF_DEEP_GATE_TWO = 12'h128;
    localparam logic [11:0] OFF_INT_STATUS = 12'h130;
    localparam logic [11:0] OFF_INT_MASK = 12'h134;
    localparam logic [11:0] OFF_FAULT_UNITS = 12'h138;
    localparam logic [11:0] OFF_ACTIVE_GATES = 12'h13C;

    // writable bits of each register
    localparam logic [31:0] MASK_GATE_ONE = 32'h0003_1011;
    localparam logic [31:0] MASK_GATE_TWO = 32'h0001_201F;
    localparam logic [31:0] MASK_CLOCK_CONFIG = 32'h0000_0001;
    localparam logic [31:0] MASK_INT = 32'h0000_0003;

    // field positions, first gating register
    localparam int BIT_ASYNC_SERIAL = 0;
    localparam int BIT_SYNC_SERIAL = 4;
    localparam int BIT_TWO_WIRE = 12;
    localparam int BIT_TIMER_ZERO = 16;
    localparam int BIT_TIMER_ONE = 17;

    // field positions, second gating register
    localparam int BIT_PORT_A = 0;
    localparam int BIT_PORT_E = 4;
    localparam int BIT_MICRO_DMA = 13;
    localparam int BIT_USB_CTRL = 16;

    // other fields
    localparam int BIT_AUTO_GATING = 0;
    localparam int BIT_EVT_FAULT = 0;
    localparam int BIT_EVT_MODE = 1;

    // reset values
    localparam logic [31:0] RST_GATE = 32'h0000_0000;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // number of gated units
    localparam int NUM_UNITS = 12;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // power modes
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP = 2'b10
    } pcg_mode_e;

endpackage : pcg_pkg

// file: rtl/pcg_clk_gate.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// glitch-free clock gate bank
// ----------------------------------------------------------------------------
module pcg_clk_gate #(
    parameter int N = 12
) (
    // source clock
    input wire logic clk_in,
    // per-unit enables, same clock
    input wire logic [N-1:0] en,
    // gated clocks
    output logic [N-1:0] clk_out
);

    logic [N-1:0] en_lat;

    // enable held while clock high, so no runt pulse
    always_latch begin
        if (!clk_in) begin
            en_lat = en; // RULE17
        end
    end

    // and-gate after the latch
    assign clk_out = {N{clk_in}} & en_lat; // RULE1

endmodule : pcg_clk_gate
`default_nettype wire

// file: rtl/pcg_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// axi4-lite slave front end
// ----------------------------------------------------------------------------
module pcg_axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register file side
    output logic wr_req,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_req,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic aw_full_q;
    logic w_full_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // handshakes
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_req = aw_full_q && w_full_q && !bvalid_q;
    assign rd_req = s_axi_arvalid && !rvalid_q;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_addr = s_axi_araddr;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= pcg_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_req) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_err ? pcg_pkg::RESP_SLVERR : pcg_pkg::RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= pcg_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (rd_req) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_err ? 32'h0000_0000 : rd_data;
            rresp_q <= rd_err ? pcg_pkg::RESP_SLVERR : pcg_pkg::RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : pcg_axil_slave
`default_nettype wire

// file: tb/pcg_props.sv
`timescale 1ns/1ps
`default_nettype none
// bus and gating checks on the top ports
module pcg_props (
    input wire logic aclk, aresetn, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
    input wire logic s_axi_arready, periph_access, periph_fault, irq,
    input wire logic [pcg_pkg::NUM_UNITS-1:0] periph_sel, unit_clk, unit_clk_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_fault; periph_fault == (periph_access && |(periph_sel & ~unit_clk_en)); endproperty
    a_fault: assert property (p_fault) else $error("fault flag wrong");
    property p_rst_en; $rose(aresetn) |-> unit_clk_en == '0 && !irq; endproperty
    a_rst_en: assert property (p_rst_en) else $error("gates not clear after reset");
    property p_rst_bus; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready; endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("bus not idle after reset");
    property p_gate; @(negedge aclk) disable iff (!aresetn) unit_clk == $past(unit_clk_en); endproperty
    a_gate: assert property (p_gate) else $error("unit clock disagrees with enable");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("write response repeated");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_arrdy; s_axi_arready == !s_axi_rvalid; endproperty
    a_arrdy: assert property (p_arrdy) else $error("read address ready wrong");
endmodule : pcg_props
bind pcg_top pcg_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_arready, .periph_access, .periph_fault, .irq, .periph_sel, .unit_clk, .unit_clk_en);
`default_nettype wire

// file: tb/pcg_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// system bus decoder: one-hot target while accessing
module pcg_bus_model (
    input wire logic aclk, go,
    input wire logic [3:0] unit,
    output logic periph_access = 1'b0,
    output logic [pcg_pkg::NUM_UNITS-1:0] periph_sel = 12'hA5A
);
    // select lines wander while idle
    always @(posedge aclk) begin
        periph_access <= go;
        periph_sel <= go ? 12'h001 << unit : ~periph_sel;
    end
endmodule : pcg_bus_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, go = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_mode = 0, deep_sleep_mode = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_access, periph_fault, irq;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, unit = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] periph_sel, unit_clk, unit_clk_en;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    pcg_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .deep_sleep_mode,
        .periph_access, .periph_sel, .periph_fault, .unit_clk, .unit_clk_en, .irq);
    pcg_bus_model model (.aclk, .go, .unit, .periph_access, .periph_sel);
    // 20 mhz clock and watchdog
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // axi4-lite write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [31:0] er);
        @(posedge aclk);
        s_axi_awaddr <= pcg_pkg::BASE_ADDR | {20'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, er);
    endtask : wr
    // axi4-lite read
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] er);
        @(posedge aclk);
        s_axi_araddr <= pcg_pkg::BASE_ADDR | {20'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, er);
    endtask : rd
    // test sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h108, 32'h0, 32'h0);
        rd(12'h118, 32'h0, 32'h0);
        wr(12'h108, 32'h0001_201F, 32'h0);
        rd(12'h108, 32'h0001_201F, 32'h0);
        wr(12'h100, 32'hFFFF_FFFF, 32'h0);
        rd(12'h100, 32'h0003_1011, 32'h0);
        chk({20'h0, unit_clk_en}, 32'hFFF);
        $display("test run gating done");
        wr(12'h118, 32'h10, 32'h0);
        wr(12'h128, 32'h1, 32'h0);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({20'h0, unit_clk_en}, 32'hFFF);
        wr(12'h060, 32'h1, 32'h0);
        repeat (3) @(posedge aclk);
        chk({20'h0, unit_clk_en}, 32'h200);
        deep_sleep_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({20'h0, unit_clk_en}, 32'h020);
        sleep_mode <= 1'b0;
        deep_sleep_mode <= 1'b0;
        $display("test mode sets done");
        wr(12'h134, 32'h1, 32'h0);
        wr(12'h100, 32'h0, 32'h0);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        chk({31'h0, periph_fault}, 32'h1);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(12'h130, 32'h3, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(12'h004, 32'h0, 32'h2);
        $display("test fault done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
